// file: tp_bus_master.sv
// Behavioural two-wire bus master that drives the slave in the bench.
`timescale 1ns/1ps
`default_nettype none
module tp_bus_master (
  input  wire logic  mclk_i,
  input  wire logic  sda_i,
  output logic       scl_o,
  output logic       sda_o,
  output logic [8:0] res_o,
  output logic       res_v_o
);
  // The bus idles with both lines released high.
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    res_o = 9'h000;
    res_v_o = 1'b0;
  end

  // Waits in core clocks; 15 clocks keep every phase far above the pin filter.
  task automatic dly(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // Start or repeated start; for a restart the clock is low on entry.
  task automatic start;
    dly(15);
    sda_o = 1'b1;
    dly(30);
    scl_o = 1'b1;
    dly(30);
    sda_o = 1'b0;
    dly(30);
    scl_o = 1'b0;
  endtask

  // Stop condition, leaving the bus idle.
  task automatic stop;
    dly(15);
    sda_o = 1'b0;
    dly(30);
    scl_o = 1'b1;
    dly(30);
    sda_o = 1'b1;
    dly(30);
  endtask

  // One clock pulse; our data moves only while the clock is low.
  task automatic bit_x(input logic b, output logic r);
    dly(15);
    sda_o = b;
    dly(15);
    scl_o = 1'b1;
    dly(15);
    r = sda_i;
    dly(15);
    scl_o = 1'b0;
  endtask

  // Hands one result to the bench watcher for a single clock.
  task automatic report(input logic [8:0] v);
    res_o = v;
    res_v_o = 1'b1;
    dly(1);
    res_v_o = 1'b0;
  endtask

  // Byte out, most significant bit first, then the acknowledge pulse.
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    report({1'b1, 7'h00, r});
  endtask

  // Byte in; the ninth pulse carries our acknowledge or its absence.
  task automatic rbyte(input logic nack);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(nack, r);
    report({1'b0, d});
  endtask
endmodule
`default_nettype wire

// file: tp_mem_if.sv
// Handshake bundle between the link-side engine and the core-side memory.
`timescale 1ns/1ps
`default_nettype none
interface tp_mem_if;
  logic        wr_req;
  logic        wr_ack;
  logic [4:0]  wr_page;
  logic [63:0] wr_data;
  logic [7:0]  wr_mask;
  logic        rd_req;
  logic        rd_ack;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;

  modport link  (output wr_req, wr_page, wr_data, wr_mask, rd_req, rd_addr,
                 input  wr_ack, rd_ack, rd_data);
  modport store (input  wr_req, wr_page, wr_data, wr_mask, rd_req, rd_addr,
                 output wr_ack, rd_ack, rd_data);
endinterface
`default_nettype wire

// file: tp_nv_store.sv
// Core-side byte memory, timed page commit and wiper registers.
`timescale 1ns/1ps
`default_nettype none
module tp_nv_store #(
  parameter int unsigned WRITE_CYCLES = tp_pkg::WRITE_CYCLES
) (
  input  wire logic  mclk_i,
  input  wire logic  rst_b_i,
  input  wire logic  ce_i,
  input  wire logic  wp_i,
  tp_mem_if.store    mem,
  output logic       write_busy_o,
  output logic [6:0] wiper0_o,
  output logic [6:0] wiper1_o,
  output logic [6:0] wiper2_o
);
  import tp_pkg::*;

  localparam int unsigned CNT_W = $clog2(WRITE_CYCLES + 1);

  logic [1:0]       req_s;
  logic             wp_s;
  logic [7:0]       mem_q [NV_BYTES];
  logic [CNT_W-1:0] tmr_q;
  logic             timing_q;
  logic             wr_ack_q;
  logic             rd_ack_q;
  logic [7:0]       rdata_q;
  logic             commit;
  logic [7:0]       slot_addr [PAGE_BYTES];
  logic [7:0]       slot_val  [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] slot_we;

  // Request levels from the link domain.
  tp_sync #(.W(2), .FILTER(1'b0), .RST_VAL(2'b00)) u_req_sync (
    .clk_i   (mclk_i),
    .rst_b_i (rst_b_i),
    .en_i    (ce_i),
    .d_i     ({mem.wr_req, mem.rd_req}),
    .q_o     (req_s)
  );

  // Write protect pin; floating reads high, so reset assumes locked.
  tp_sync #(.W(1), .FILTER(1'b1), .RST_VAL(1'b1)) u_wp_sync (
    .clk_i   (mclk_i),
    .rst_b_i (rst_b_i),
    .en_i    (ce_i),
    .d_i     (wp_i),
    .q_o     (wp_s)
  );

  assign commit = ce_i & req_s[1] & ~timing_q & ~wr_ack_q;

  // Per-slot address, value and enable for a page commit.
  genvar gi;
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++)
    begin : g_slot
      logic is_wiper;
      logic [7:0] byte_v;
      assign slot_addr[gi] = {mem.wr_page, 3'(gi)};
      assign is_wiper = (slot_addr[gi] >= POT1_ADDR) && (slot_addr[gi] <= POT2_ADDR);
      assign byte_v = mem.wr_data[gi*8 +: 8];
      assign slot_val[gi] = is_wiper ? (byte_v & WIPER_MASK) : byte_v;
      assign slot_we[gi] = commit & mem.wr_mask[gi] & ~(is_wiper & wp_s);
    end
  endgenerate

  // Timed write: busy for the configured cycles, then answer the request.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      timing_q <= 1'b0;
      wr_ack_q <= 1'b0;
      tmr_q    <= '0;
    end
    else if (ce_i)
    begin
      if (commit)
      begin
        timing_q <= 1'b1;
        tmr_q    <= CNT_W'(WRITE_CYCLES - 1);
      end
      else if (timing_q)
      begin
        if (tmr_q == '0)
        begin
          timing_q <= 1'b0;
          wr_ack_q <= 1'b1;
        end
        else
        begin
          tmr_q <= tmr_q - 1'b1;
        end
      end
      else if (wr_ack_q && !req_s[1])
      begin
        wr_ack_q <= 1'b0;
      end
    end
  end

  // Memory array has no reset: it models contents kept while powered.
  always_ff @(posedge mclk_i)
  begin
    for (int i = 0; i < PAGE_BYTES; i++)
    begin
      if (slot_we[i])
      begin
        mem_q[slot_addr[i]] <= slot_val[i];
      end
    end
  end

  // Wiper outputs follow committed writes to their locations.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      wiper0_o <= WIPER_RST;
      wiper1_o <= WIPER_RST;
      wiper2_o <= WIPER_RST;
    end
    else
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (slot_we[i] && slot_addr[i] == POT0_ADDR)
        begin
          wiper0_o <= slot_val[i][6:0];
        end
        if (slot_we[i] && slot_addr[i] == POT1_ADDR)
        begin
          wiper1_o <= slot_val[i][6:0];
        end
        if (slot_we[i] && slot_addr[i] == POT2_ADDR)
        begin
          wiper2_o <= slot_val[i][6:0];
        end
      end
    end
  end

  // Read handshake; data stays stable while the answer is high.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      rd_ack_q <= 1'b0;
      rdata_q  <= '0;
    end
    else if (ce_i)
    begin
      if (req_s[0] && !rd_ack_q)
      begin
        rdata_q  <= mem_q[mem.rd_addr];
        rd_ack_q <= 1'b1;
      end
      else if (!req_s[0])
      begin
        rd_ack_q <= 1'b0;
      end
    end
  end

  assign mem.wr_ack   = wr_ack_q;
  assign mem.rd_ack   = rd_ack_q;
  assign mem.rd_data  = rdata_q;
  assign write_busy_o = timing_q;

endmodule
`default_nettype wire

// file: tp_pkg.sv
// Shared constants and types for the two-wire potentiometer memory slave.
package tp_pkg;

  // Core clock and nonvolatile write timing.
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned WRITE_TIME_NS = 10000;
  localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Memory geometry.
  localparam int unsigned NV_BYTES   = 256;
  localparam int unsigned PAGE_BYTES = 8;

  // Wiper locations and the bits they keep.
  localparam logic [7:0] POT1_ADDR  = 8'hF8;
  localparam logic [7:0] POT0_ADDR  = 8'hF9;
  localparam logic [7:0] POT2_ADDR  = 8'hFA;
  localparam logic [7:0] WIPER_MASK = 8'h7F;

  // Bit counter value of the acknowledge slot.
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Device type code; the value is arbitrary.
  localparam logic [5:0] DEV_TYPE_DEFAULT = 6'h2B;

  // Filtered pin levels at reset: {ce, select, data, clock}.
  localparam logic [3:0] LINK_PIN_RST = 4'h3;

  // Reset values of the wiper outputs and memory pointer.
  localparam logic [6:0] WIPER_RST = 7'h00;
  localparam logic [7:0] PTR_RST   = 8'h00;

  // Protocol states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DEV   = 3'b001,
    ST_WORD  = 3'b011,
    ST_WDATA = 3'b010,
    ST_READ  = 3'b110
  } tp_state_t;

endpackage

// file: tp_pot_slave.sv
// Two-wire slave port giving a bus master access to the wiper memory.
//
// Summary of operation
// - Ignore the bus during the internal write.
// - Accept page writes of up to eight bytes.
// - Page write address wraps within its page.
// - Commit written bytes only on a stop.
// - Address acknowledged only after write finishes.
// - Read direction bit selects read mode.
// - Pointer is last address plus one; after writes it wraps within the page.
// - Current read sends pointer byte after acknowledge.
// - Each master acknowledge sends next byte, wrapping.
// - Device is slave only; never drives clock.
// - Data edges with clock high mark start, stop.
// - Data changes only while clock low.
// - Bytes plus ninth acknowledge bit, any count.
// - Works at regular and fast clock rates.
// - Acknowledge holds data low through clock high.
// - Release data line after master nack.
// - Type code, select pin, direction; mismatch idles.
// - Byte write: address, word, data, then stop.
// - Wiper locations keep only seven bits.
// - Wipers change only with write protect low.
`timescale 1ns/1ps
`default_nettype none
module tp_pot_slave #(
  parameter logic [5:0]  DEVICE_TYPE  = tp_pkg::DEV_TYPE_DEFAULT,
  parameter int unsigned WRITE_CYCLES = tp_pkg::WRITE_CYCLES
) (
  input  wire logic  mclk_i,
  input  wire logic  rst_b_i,
  input  wire logic  ce_i,
  input  wire logic  link_clk_i,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  output logic       sda_o,
  output logic       sda_oe_b_o,
  input  wire logic  device_select_pin_i,
  input  wire logic  wp_i,
  output logic       write_busy_o,
  output logic [6:0] wiper0_o,
  output logic [6:0] wiper1_o,
  output logic [6:0] wiper2_o
);
  import tp_pkg::*;

  tp_mem_if u_mem_if ();

  logic            lrst_b;
  logic [3:0]      pins_s;
  logic            scl_s;
  logic            sda_s;
  logic            dsel_s;
  logic            ce_l;
  logic [1:0]      ack_s;
  logic            scl_p_q;
  logic            sda_p_q;
  tp_state_t       st_q;
  logic [3:0]      bit_q;
  logic            ack_q;
  logic [7:0]      sh_q;
  logic [7:0]      tx_q;
  logic            oe_b_q;
  logic [7:0]      ptr_q;
  logic            rd_req_q;
  logic [7:0]      rd_addr_q;
  logic [7:0]      rdata_q;
  logic            wr_req_q;
  logic [4:0]      page_q;
  logic [PAGE_BYTES-1:0][7:0] buf_q;
  logic [PAGE_BYTES-1:0]      mask_q;
  logic            busy_l;
  logic            rise;
  logic            fall;
  logic            start;
  logic            stop;
  logic            slot_fall;
  logic            dev_match;
  logic            dev_ok;
  logic            word_ok;
  logic            data_ok;
  logic            m_ack;
  logic            rd_go;
  logic            commit_go;

  // Core reset carried into the link domain.
  tp_sync #(.W(1), .FILTER(1'b0), .RST_VAL(1'b0)) u_rst_sync (
    .clk_i   (link_clk_i),
    .rst_b_i (1'b1),
    .en_i    (1'b1),
    .d_i     (rst_b_i),
    .q_o     (lrst_b)
  );

  // Bus pins, select pin and clock enable, filtered on the link clock.
  tp_sync #(.W(4), .FILTER(1'b1), .RST_VAL(LINK_PIN_RST)) u_pin_sync (
    .clk_i   (link_clk_i),
    .rst_b_i (lrst_b),
    .en_i    (1'b1),
    .d_i     ({ce_i, device_select_pin_i, sda_i, scl_i}),
    .q_o     (pins_s)
  );

  // Answers from the memory side.
  tp_sync #(.W(2), .FILTER(1'b0), .RST_VAL(2'b00)) u_ack_sync (
    .clk_i   (link_clk_i),
    .rst_b_i (lrst_b),
    .en_i    (ce_l),
    .d_i     ({u_mem_if.wr_ack, u_mem_if.rd_ack}),
    .q_o     (ack_s)
  );

  assign scl_s  = pins_s[0];
  assign sda_s  = pins_s[1];
  assign dsel_s = pins_s[2];
  assign ce_l   = pins_s[3];

  // Previous levels for edge and condition detection.
  always_ff @(posedge link_clk_i)
  begin
    if (!lrst_b)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else if (ce_l)
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Bus events. The link clock is far faster than either bus rate,
  // so every clock phase spans many samples.
  assign rise  = scl_s & ~scl_p_q;
  assign fall  = ~scl_s & scl_p_q;
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // The write stays busy from the commit request until the answer clears.
  assign busy_l = wr_req_q | ack_s[1];

  // Byte decisions are taken on the falling edge that opens the ninth slot.
  assign slot_fall = fall & (bit_q == ACK_SLOT) & ~ack_q;
  assign dev_match = (sh_q[7:2] == DEVICE_TYPE) && (sh_q[1] == dsel_s);
  assign dev_ok    = (st_q == ST_DEV) & slot_fall & dev_match;
  assign word_ok   = (st_q == ST_WORD) & slot_fall;
  assign data_ok   = (st_q == ST_WDATA) & slot_fall;
  assign m_ack     = (st_q == ST_READ) & rise & (bit_q == ACK_SLOT) & ack_q & oe_b_q & ~sda_s;
  assign rd_go     = (dev_ok & sh_q[0]) | m_ack;
  assign commit_go = stop & (st_q == ST_WDATA) & (mask_q != '0);

  // Protocol engine: bit counting, acknowledge slots and data drive.
  always_ff @(posedge link_clk_i)
  begin
    if (!lrst_b)
    begin
      st_q   <= ST_IDLE;
      bit_q  <= '0;
      ack_q  <= 1'b0;
      sh_q   <= '0;
      tx_q   <= '0;
      oe_b_q <= 1'b1;
    end
    else if (ce_l)
    begin
      if (start)
      begin
        oe_b_q <= 1'b1;
        ack_q  <= 1'b0;
        bit_q  <= '0;
        st_q   <= busy_l ? ST_IDLE : ST_DEV;
      end
      else if (stop)
      begin
        oe_b_q <= 1'b1;
        ack_q  <= 1'b0;
        bit_q  <= '0;
        st_q   <= ST_IDLE;
      end
      else if (st_q != ST_IDLE)
      begin
        if (rise)
        begin
          if (bit_q != ACK_SLOT)
          begin
            sh_q  <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 1'b1;
          end
          else if (st_q == ST_READ && ack_q && sda_s)
          begin
            st_q <= ST_IDLE;
          end
        end
        else if (fall)
        begin
          if (ack_q)
          begin
            // End of the ninth clock: release or start the next byte.
            ack_q <= 1'b0;
            bit_q <= '0;
            if (st_q == ST_READ)
            begin
              oe_b_q <= rdata_q[7];
              tx_q   <= {rdata_q[6:0], 1'b0};
            end
            else
            begin
              oe_b_q <= 1'b1;
            end
          end
          else if (bit_q == ACK_SLOT)
          begin
            ack_q <= 1'b1;
            case (st_q)
              ST_DEV:
              begin
                if (dev_match)
                begin
                  oe_b_q <= 1'b0;
                  st_q   <= sh_q[0] ? ST_READ : ST_WORD;
                end
                else
                begin
                  st_q <= ST_IDLE;
                end
              end
              ST_WORD:
              begin
                oe_b_q <= 1'b0;
                st_q   <= ST_WDATA;
              end
              ST_WDATA:
              begin
                oe_b_q <= 1'b0;
              end
              ST_READ:
              begin
                oe_b_q <= 1'b1;
              end
              default:
              begin
                st_q <= ST_IDLE;
              end
            endcase
          end
          else if (st_q == ST_READ && bit_q != '0)
          begin
            oe_b_q <= tx_q[7];
            tx_q   <= {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Address pointer: word load, in-page step on writes, free step on reads.
  always_ff @(posedge link_clk_i)
  begin
    if (!lrst_b)
    begin
      ptr_q <= PTR_RST;
    end
    else if (ce_l)
    begin
      if (word_ok)
      begin
        ptr_q <= sh_q;
      end
      else if (data_ok)
      begin
        ptr_q <= {ptr_q[7:3], ptr_q[2:0] + 3'h1};
      end
      else if (rd_go)
      begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // Read fetch. A fetch takes well under a bus clock high phase, so the
  // byte is ready before its first bit is driven.
  always_ff @(posedge link_clk_i)
  begin
    if (!lrst_b)
    begin
      rd_req_q  <= 1'b0;
      rd_addr_q <= '0;
      rdata_q   <= '0;
    end
    else if (ce_l)
    begin
      if (rd_go)
      begin
        rd_req_q  <= 1'b1;
        rd_addr_q <= ptr_q;
      end
      else if (rd_req_q && ack_s[0])
      begin
        rd_req_q <= 1'b0;
        rdata_q  <= u_mem_if.rd_data;
      end
    end
  end

  // Page buffer; bytes are only passed on once a stop closes the write.
  always_ff @(posedge link_clk_i)
  begin
    if (!lrst_b)
    begin
      wr_req_q <= 1'b0;
      page_q   <= '0;
      buf_q    <= '0;
      mask_q   <= '0;
    end
    else if (ce_l)
    begin
      if (word_ok)
      begin
        mask_q <= '0;
        page_q <= sh_q[7:3];
      end
      else if (data_ok)
      begin
        buf_q[ptr_q[2:0]]  <= sh_q;
        mask_q[ptr_q[2:0]] <= 1'b1;
      end
      else if (commit_go)
      begin
        wr_req_q <= 1'b1;
      end
      else if (wr_req_q && ack_s[1])
      begin
        wr_req_q <= 1'b0;
        mask_q   <= '0;
      end
    end
  end

  assign u_mem_if.wr_req  = wr_req_q;
  assign u_mem_if.wr_page = page_q;
  assign u_mem_if.wr_data = buf_q;
  assign u_mem_if.wr_mask = mask_q;
  assign u_mem_if.rd_req  = rd_req_q;
  assign u_mem_if.rd_addr = rd_addr_q;

  // Open-drain data: only ever pulls low; the clock is never driven.
  assign sda_o      = 1'b0;
  assign sda_oe_b_o = oe_b_q;

  tp_nv_store #(.WRITE_CYCLES(WRITE_CYCLES)) u_store (
    .mclk_i       (mclk_i),
    .rst_b_i      (rst_b_i),
    .ce_i         (ce_i),
    .wp_i         (wp_i),
    .mem          (u_mem_if),
    .write_busy_o (write_busy_o),
    .wiper0_o     (wiper0_o),
    .wiper1_o     (wiper1_o),
    .wiper2_o     (wiper2_o)
  );

endmodule
`default_nettype wire

// file: tp_pot_slave_assertions.sv
// Concurrent checks on the ports of the two-wire potentiometer slave.
`timescale 1ns/1ps
`default_nettype none
module tp_pot_slave_assertions #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic       link_clk_i,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_b_o,
  input wire logic       wp_i,
  input wire logic       write_busy_o,
  input wire logic [6:0] wiper0_o,
  input wire logic [6:0] wiper1_o,
  input wire logic [6:0] wiper2_o
);
  // Length of the current busy stretch in core clocks; a counter avoids a long repetition.
  logic [15:0] busy_cnt_q;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      busy_cnt_q <= 16'h0000;
    else if (write_busy_o)
      busy_cnt_q <= busy_cnt_q + 16'h0001;
    else
      busy_cnt_q <= 16'h0000;
  end

  // Steps of a commit: wipers move on the same edge that starts the write timer.
  sequence s_wiper_move;
    $changed({wiper0_o, wiper1_o, wiper2_o});
  endsequence
  sequence s_busy_start;
    $rose(write_busy_o);
  endsequence

  chk_sda_drives_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    sda_o == 1'b0) else $error("Data output is not a low drive.");
  chk_oe_stable_high: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    scl_i && $past(scl_i) |-> $stable(sda_oe_b_o)) else $error("Data moved in clock high.");
  chk_oe_change_low: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    $changed(sda_oe_b_o) |-> !scl_i && !$past(scl_i, 3)) else $error("Data change too early.");
  chk_busy_no_ack: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    write_busy_o |-> sda_oe_b_o) else $error("Bus answered during write.");
  chk_busy_length: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $fell(write_busy_o) |-> busy_cnt_q == 16'(WRITE_CYCLES)) else $error("Write time wrong.");
  chk_busy_holds: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_busy_start |-> write_busy_o [*8]) else $error("Write timer dropped early.");
  chk_wiper_commit: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_wiper_move |-> ##[1:8] write_busy_o) else $error("Wiper moved without commit.");
  chk_wiper_locked: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wp_i && $past(wp_i, 5) |-> $stable({wiper0_o, wiper1_o, wiper2_o}))
    else $error("Wiper moved while protected.");
endmodule

bind tp_pot_slave tp_pot_slave_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o), .wp_i(wp_i), .write_busy_o(write_busy_o),
  .wiper0_o(wiper0_o), .wiper1_o(wiper1_o), .wiper2_o(wiper2_o));
`default_nettype wire

// file: tp_pot_slave_bench.sv
// Self-checking bench for the two-wire potentiometer slave.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end
module tp_pot_slave_bench;
  import tp_pkg::*;
  localparam int unsigned WC = 1000;
  logic       mclk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       wp = 1'b0;
  logic       dsel = 1'b1;
  logic       scl, m_sda, sda, oe_b, sda_out, busy, m_v;
  logic [6:0] w0, w1, w2;
  logic [8:0] m_res, exp_v;
  logic [8:0] exp_q[$];
  logic [7:0] mem[256];
  logic [7:0] ptr = 8'h00;
  int         mismatches = 0;
  int         checks_done = 0;
  int         cyc = 0;

  // Core clock, and a link clock of unrelated phase.
  always #2.5 mclk = ~mclk;
  initial #1.1 forever #3 link_clk = ~link_clk;

  // Open-drain data wire with its pull-up.
  assign sda = m_sda & (oe_b ? 1'b1 : sda_out);

  tp_pot_slave #(.WRITE_CYCLES(WC)) dut_u (.mclk_i(mclk), .rst_b_i(rst_b), .ce_i(1'b1),
    .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe_b_o(oe_b),
    .device_select_pin_i(dsel), .wp_i(wp), .write_busy_o(busy), .wiper0_o(w0),
    .wiper1_o(w1), .wiper2_o(w2));
  tp_bus_master m_u (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda),
    .res_o(m_res), .res_v_o(m_v));

  // Each master result against the oldest note; a stuck run is cut short.
  always @(posedge mclk)
  begin
    cyc++;
    if (m_v === 1'b1)
    begin
      exp_v = exp_q.pop_front();
      `CHK(m_res, exp_v)
    end
    if (cyc == 90000)
    begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report;
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] addr(input logic rw);
    return {DEV_TYPE_DEFAULT, dsel, rw};
  endfunction

  task automatic send(input logic [7:0] b, input logic ack);
    exp_q.push_back({1'b1, 7'h00, ack});
    m_u.wbyte(b);
  endtask

  // Sequential read from the pointer; the last byte is left unacknowledged.
  task automatic recv(input int n);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back({1'b0, mem[ptr]});
      ptr++;
      m_u.rbyte(i == n - 1);
    end
  endtask

  // Commit must start the timer, and the timer must end in bounded time.
  task automatic wait_commit;
    int k;
    k = 0;
    while (busy !== 1'b1 && k < 100)
    begin
      @(negedge mclk);
      k++;
    end
    `CHK(busy, 1'b1)
    while (busy !== 1'b0 && k < WC + 200)
    begin
      @(negedge mclk);
      k++;
    end
    `CHK(busy, 1'b0)
  endtask

  // Page write of n random bytes; without a stop nothing is kept.
  task automatic pg_wr(input logic [7:0] w, input int n, input bit stp);
    logic [7:0] a;
    logic [7:0] av[8];
    logic [7:0] dv[8];
    m_u.start();
    send(addr(1'b0), 1'b0);
    send(w, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      av[i] = {w[7:3], w[2:0] + i[2:0]};
      dv[i] = 8'($urandom);
      send(dv[i], 1'b0);
    end
    ptr = {w[7:3], w[2:0] + n[2:0]};
    if (stp)
    begin
      m_u.stop();
      for (int i = 0; i < n; i++)
      begin
        a = av[i];
        if (a inside {[8'hF8:8'hFA]})
        begin
          if (!wp)
            mem[a] = dv[i] & WIPER_MASK;
        end
        else
          mem[a] = dv[i];
      end
    end
  endtask

  // Random read: word address only, then a restart in the read direction.
  task automatic rd(input logic [7:0] w, input int n);
    pg_wr(w, 0, 1'b0);
    m_u.start();
    send(addr(1'b1), 1'b0);
    recv(n);
    m_u.stop();
    `CHK(sda, 1'b1)
  endtask

  task automatic chk_wipers;
    `CHK({w1, w0, w2}, {mem[8'hF8][6:0], mem[8'hF9][6:0], mem[8'hFA][6:0]})
  endtask

  // Main sequence.
  initial
  begin
    void'($urandom(53));
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    repeat (20) @(negedge mclk);
    pg_wr(8'h00, 8, 1'b1);
    m_u.start();
    send(addr(1'b0), 1'b1);
    m_u.stop();
    wait_commit();
    m_u.start();
    send(addr(1'b1), 1'b0);
    recv(1);
    m_u.stop();
    pg_wr(8'hF8, 8, 1'b1);
    wait_commit();
    chk_wipers();
    wp = 1'b1;
    pg_wr(8'hF8, 8, 1'b1);
    wait_commit();
    chk_wipers();
    pg_wr(8'h0D, 8, 1'b1);
    wait_commit();
    rd(8'h08, 8);
    rd(8'hF8, 10);
    m_u.start();
    send(addr(1'b1), 1'b0);
    recv(1);
    m_u.stop();
    pg_wr(8'h20, 1, 1'b1);
    wait_commit();
    pg_wr(8'h20, 1, 1'b0);
    rd(8'h20, 1);
    m_u.start();
    send({DEV_TYPE_DEFAULT, 1'b0, 1'b0}, 1'b1);
    m_u.start();
    send({~DEV_TYPE_DEFAULT, 1'b1, 1'b1}, 1'b1);
    m_u.stop();
    dsel = 1'b0;
    m_u.start();
    send(addr(1'b0), 1'b0);
    m_u.stop();
    repeat (20) @(negedge mclk);
    final_report();
  end
endmodule
`default_nettype wire

// file: tp_sync.sv
// Multi-bit level synchroniser with an optional agreement filter for pins.
`timescale 1ns/1ps
`default_nettype none
module tp_sync #(
  parameter int unsigned    W       = 1,
  parameter bit             FILTER  = 1'b0,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // Two plain stages; the first stage feeds only the second.
  always_ff @(posedge clk_i)
  begin
    if (en_i)
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  generate
    if (FILTER)
    begin : g_filt
      logic [W-1:0] s3_q;
      logic [W-1:0] clean_q;
      logic [W-1:0] agree;

      // A change only counts once the second and third stages agree.
      assign agree = ~(s2_q ^ s3_q);

      always_ff @(posedge clk_i)
      begin
        if (en_i)
        begin
          s3_q <= s2_q;
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (!rst_b_i)
        begin
          clean_q <= RST_VAL;
        end
        else if (en_i)
        begin
          clean_q <= (clean_q & ~agree) | (s3_q & agree);
        end
      end

      assign q_o = clean_q;
    end
    else
    begin : g_plain
      assign q_o = s2_q;
    end
  endgenerate

endmodule
`default_nettype wire
